// ===== core/ubx_ctrl.sv
// ubx_ctrl: break exception control beside the core pipeline
// assumes the core reports retire, mask flag and competing exceptions per cycle
// What this block does
// - pre-execution break: own address saved, not executed
// - post-execution break: save next instruction address
// - delayed branch: slot runs, save target or fallthrough
// - operand address break saves following instruction address
// - address+data break fires one to four later
// - competing exception: save first suppressed address
// - async interrupt contention: break vector and code
// - chained A-instr/B-operand needs gap of two
// - two accesses in one instruction: A arms, B does not chain
// - mask flag sampled before, OR, or after
// - return delay slot mask follows saved status
// - accepted exception presents mask flag as one
// - same saved_pc from both: one break, two flags
// - pre/post select only for instruction breaks
// - channel B match resets chain state
// - re-execution exception beats multistep post break
// - post break yields to completion exceptions, flags set
// - debug vector enable redirects to debug base
// - every exception copies to saved stack pointer
// - mask flag one: set flag only, no exception
// - flags only set by hardware, cleared by software
`timescale 1ns/1ps
`default_nettype none
module ubx_ctrl
  import ubx_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     retire,
  input  wire logic [ubx_pkg::PC_W-1:0] retire_pc,
  input  wire logic [ubx_pkg::PC_W-1:0] next_pc,
  input  wire logic                     is_delayed_branch,
  input  wire logic                     branch_taken,
  input  wire logic [ubx_pkg::PC_W-1:0] branch_target,
  input  wire logic                     is_rte_slot,
  input  wire logic                     saved_status_mask,
  input  wire logic                     mask_before,
  input  wire logic                     mask_after,
  input  wire logic                     instr_match_a,
  input  wire logic                     instr_match_b,
  input  wire logic                     opnd_match_a,
  input  wire logic                     opnd_match_b,
  input  wire logic                     data_compare_en,
  input  wire logic                     instr_cfg_a,
  input  wire logic                     instr_cfg_b,
  input  wire logic                     pre_post_select_a,
  input  wire logic                     pre_post_select_b,
  input  wire logic                     chained_mode_bit,
  input  wire logic                     debug_vector_enable,
  input  wire logic [ubx_pkg::PC_W-1:0] debug_vector_base,
  input  wire logic [ubx_pkg::PC_W-1:0] vector_base,
  input  wire logic                     break_control_wr,
  input  wire logic                     clear_flag_a,
  input  wire logic                     clear_flag_b,
  input  wire logic                     other_exc,
  input  wire logic                     other_exc_async,
  input  wire logic                     other_exc_reexec,
  input  wire logic                     other_exc_complete,
  input  wire logic [ubx_pkg::PC_W-1:0] other_exc_pc,
  input  wire logic [ubx_pkg::PC_W-1:0] other_exc_vector,
  input  wire logic [ubx_pkg::EVT_W-1:0] other_exc_code,
  input  wire logic [ubx_pkg::PC_W-1:0] gpr15,
  output logic                          exc_take,
  output logic                          suppress_exec,
  output logic [ubx_pkg::PC_W-1:0]      saved_pc,
  output logic [ubx_pkg::PC_W-1:0]      exc_vector,
  output logic [ubx_pkg::EVT_W-1:0]     exception_event_code,
  output logic [ubx_pkg::PC_W-1:0]      saved_stack_pointer,
  output logic                          exception_mask_flag,
  output logic                          match_flag_a,
  output logic                          match_flag_b
);
  import ubx_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // channel classification and flags
  ubx_kind_t kind_a;
  ubx_kind_t kind_b;
  logic      hit_a;
  logic      hit_b;
  logic      set_a;
  logic      set_b;
  logic      flag_a_q;
  logic      flag_b_q;

  ubx_chan u_chan_a
  (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .instr_match     (instr_match_a),
    .opnd_match      (opnd_match_a),
    .is_instr_cfg    (instr_cfg_a),
    .pre_post_select (pre_post_select_a),
    .set_flag        (set_a),
    .clear_flag      (break_control_wr && clear_flag_a),
    .kind            (kind_a),
    .match_flag      (flag_a_q)
  );

  ubx_chan u_chan_b
  (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .instr_match     (instr_match_b),
    .opnd_match      (opnd_match_b),
    .is_instr_cfg    (instr_cfg_b),
    .pre_post_select (pre_post_select_b),
    .set_flag        (set_b),
    .clear_flag      (break_control_wr && clear_flag_b),
    .kind            (kind_b),
    .match_flag      (flag_b_q)
  );

  ////////////////////////////////////////////////////////////////////
  // chain state: A armed waits for B
  logic      chain_armed_reg;
  logic [1:0] since_a_reg;
  logic      chain_fire;

  // B instruction must be three or more after the arming A instruction for an
  // operand B; closer spacing is not promised, so it is simply not chained
  assign chain_fire = chained_mode_bit && chain_armed_reg && (kind_b != UBX_K_NONE)
                      && ((kind_b != UBX_K_OPND) || (since_a_reg >= CHAIN_MIN_GAP));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chain_armed_reg <= 1'b0;
      since_a_reg     <= 2'h0;
    end
    else if (ce)
    begin
      if (!chained_mode_bit)
        chain_armed_reg <= 1'b0;
      else if (kind_b != UBX_K_NONE && chain_armed_reg)
        chain_armed_reg <= 1'b0;
      else if (kind_a != UBX_K_NONE)
      begin
        // an A access earlier in the same instruction arms before a later B
        chain_armed_reg <= 1'b1;
        since_a_reg     <= 2'h0;
      end
      if (retire && chain_armed_reg && since_a_reg != 2'h3)
        since_a_reg <= since_a_reg + 2'h1;
    end
  end

  assign hit_a = !chained_mode_bit && (kind_a != UBX_K_NONE);
  assign hit_b = chained_mode_bit ? chain_fire : (kind_b != UBX_K_NONE);

  ////////////////////////////////////////////////////////////////////
  // mask value referenced by the break kind
  function automatic logic mask_for(input ubx_kind_t k, input logic mb, input logic ma);
    case (k)
      UBX_K_IPRE:  mask_for = mb;
      UBX_K_IPOST: mask_for = mb | ma;
      UBX_K_OPND:  mask_for = ma;
      default:     mask_for = 1'b1;
    endcase
  endfunction

  logic      mb_eff;
  logic      ma_eff;
  ubx_kind_t kind_sel;
  logic      post_blocked;
  logic      want_now;
  logic      want_defer;
  logic      data_brk;
  logic [PC_W-1:0] pc_sel;

  // in a return delay slot the after-value is the saved status mask
  assign mb_eff = mask_before;
  assign ma_eff = is_rte_slot ? saved_status_mask : mask_after;
  assign kind_sel = hit_a ? kind_a : (hit_b ? kind_b : UBX_K_NONE);

  // flags still set when the post break loses priority
  assign set_a = hit_a;
  // chained mode sets only the B flag; both flags set when both hit at once
  assign set_b = hit_b;

  assign post_blocked = (kind_sel == UBX_K_IPOST) && (other_exc_reexec || other_exc_complete);
  assign want_now   = (hit_a || hit_b) && !mask_for(kind_sel, mb_eff, ma_eff)
                      && !post_blocked && !data_brk;
  // only channel B compares data, so only a B operand match is deferred
  assign data_brk   = (kind_sel == UBX_K_OPND) && !hit_a && hit_b && data_compare_en;
  assign want_defer = (hit_a || hit_b) && !mask_for(kind_sel, mb_eff, ma_eff) && data_brk;

  always_comb
  begin
    pc_sel = next_pc;
    case (kind_sel)
      UBX_K_IPRE:  pc_sel = retire_pc;
      UBX_K_IPOST:
      begin
        if (is_delayed_branch)
          pc_sel = branch_taken ? branch_target : next_pc + {30'h0, PC_STEP};
        else
          pc_sel = next_pc;
      end
      UBX_K_OPND:  pc_sel = next_pc;
      default:     pc_sel = next_pc;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // exception sequencing
  ubx_state_t      state_reg;
  logic [CNT_W-1:0] defer_cnt_reg;
  logic [PC_W-1:0] pend_pc_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg     <= UBX_IDLE;
      defer_cnt_reg <= '0;
      pend_pc_reg   <= PC_RST;
    end
    else if (ce)
    begin
      case (state_reg)
        UBX_IDLE:
        begin
          if (want_defer)
          begin
            state_reg     <= UBX_DEFER;
            defer_cnt_reg <= 3'h1;
            pend_pc_reg   <= next_pc;
          end
        end
        UBX_DEFER:
        begin
          // raise at the latest after four instructions, earlier on a fault
          if (other_exc || (retire && defer_cnt_reg == DATA_BRK_MAX))
            state_reg <= UBX_IDLE;
          else if (retire)
          begin
            defer_cnt_reg <= defer_cnt_reg + 3'h1;
            pend_pc_reg   <= next_pc;
          end
        end
        default:
          state_reg <= UBX_IDLE;
      endcase
    end
  end

  logic defer_fire;
  assign defer_fire = (state_reg == UBX_DEFER)
                      && (other_exc || (retire && defer_cnt_reg == DATA_BRK_MAX));

  ////////////////////////////////////////////////////////////////////
  // registered exception outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exc_take             <= 1'b0;
      suppress_exec        <= 1'b0;
      saved_pc             <= PC_RST;
      exc_vector           <= PC_RST;
      exception_event_code <= '0;
      saved_stack_pointer  <= PC_RST;
      exception_mask_flag  <= 1'b0;
    end
    else if (ce)
    begin
      exc_take      <= 1'b0;
      suppress_exec <= 1'b0;
      exception_mask_flag <= is_rte_slot ? saved_status_mask : mask_after;
      if (want_now || defer_fire || other_exc)
      begin
        exc_take            <= 1'b1;
        exception_mask_flag <= 1'b1;
        saved_stack_pointer <= gpr15;
        suppress_exec       <= want_now && kind_sel == UBX_K_IPRE;
        if (defer_fire && other_exc)
          saved_pc <= other_exc_pc;
        else if (defer_fire)
          saved_pc <= retire ? next_pc : pend_pc_reg;
        else if (want_now)
          saved_pc <= pc_sel;
        else
          saved_pc <= other_exc_pc;
        // break owns vector and code unless a synchronous fault competes with a non-deferred break;
        // for a deferred break the choice is free, so the break is kept there
        if ((want_now || defer_fire) && !(other_exc && !other_exc_async && !defer_fire))
        begin
          exception_event_code <= BRK_EVT_CODE;
          exc_vector <= debug_vector_enable ? debug_vector_base
                                            : vector_base + BRK_VEC_OFS;
        end
        else
        begin
          exception_event_code <= other_exc_code;
          exc_vector           <= other_exc_vector;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
    end
    else if (ce)
    begin
      match_flag_a <= flag_a_q;
      match_flag_b <= flag_b_q;
    end
  end
endmodule
`default_nettype wire

// ===== core/ubx_pkg.sv
// ubx_pkg: constants and types for the break exception control block
// assumes a 32-bit program counter and one core clock at 10 MHz
package ubx_pkg;
  localparam int unsigned PC_W          = 32;
  localparam int unsigned EVT_W         = 12;
  localparam int unsigned CNT_W         = 3;
  // longest deferral of an address-plus-data break, in instructions
  localparam logic [2:0]  DATA_BRK_MAX  = 3'h4;
  // least spacing between A instruction and B operand in chained mode
  localparam logic [1:0]  CHAIN_MIN_GAP = 2'h2;
  localparam logic [11:0] BRK_EVT_CODE  = 12'h1E0;
  localparam logic [31:0] BRK_VEC_OFS   = 32'h0000_0100;
  localparam logic [31:0] PC_RST        = 32'h0000_0000;
  localparam logic [1:0]  PC_STEP       = 2'h2;

  typedef enum logic [1:0]
  {
    UBX_IDLE    = 2'b00,
    UBX_DEFER   = 2'b01,
    UBX_TAKE    = 2'b11
  } ubx_state_t;

  // kind of break match reported by a channel comparator
  typedef enum logic [1:0]
  {
    UBX_K_NONE  = 2'b00,
    UBX_K_IPRE  = 2'b01,
    UBX_K_IPOST = 2'b10,
    UBX_K_OPND  = 2'b11
  } ubx_kind_t;
endpackage

// ===== core/ubx_chan.sv
// ubx_chan: one break channel, classifies a match and keeps its flag
// assumes match inputs are single-cycle pulses from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module ubx_chan
  import ubx_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  input  wire logic      instr_match,
  input  wire logic      opnd_match,
  input  wire logic      is_instr_cfg,
  input  wire logic      pre_post_select,
  input  wire logic      set_flag,
  input  wire logic      clear_flag,
  output ubx_pkg::ubx_kind_t kind,
  output logic           match_flag
);
  always_comb
  begin
    kind = UBX_K_NONE;
    // pre/post select only meaningful for instruction breaks
    if (is_instr_cfg && instr_match)
      kind = pre_post_select ? UBX_K_IPOST : UBX_K_IPRE;
    else if (!is_instr_cfg && opnd_match)
      kind = UBX_K_OPND;
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      match_flag <= 1'b0;
    else if (ce)
    begin
      if (set_flag)
        match_flag <= 1'b1;
      else if (clear_flag)
        match_flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== test/ubx_core_model.sv
// ubx_core_model: minimal core retire stream feeding the break block
// assumes one instruction retires per cycle while run is high
`timescale 1ns/1ps
`default_nettype none
module ubx_core_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        exc_take,
  input  wire logic [31:0] exc_vector,
  output logic             retire,
  output logic [31:0]      retire_pc,
  output logic [31:0]      next_pc
);
  // 16-bit instructions; stream never holds the halt instruction
  assign next_pc = retire_pc + 32'h0000_0002;
  always_ff @(posedge clk)
    retire <= run && !rst;
  // a taken break redirects the stream to the handler
  always_ff @(posedge clk)
    if (rst)
      retire_pc <= 32'h0000_1000;
    else if (exc_take)
      retire_pc <= exc_vector;
    else if (retire)
      retire_pc <= next_pc;
endmodule
`default_nettype wire

// ===== test/ubx_ctrl_chk.sv
// ubx_ctrl_chk: timing checks on the break control ports
// assumes bound to ubx_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ubx_ctrl_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        retire,
  input wire logic [31:0] retire_pc,
  input wire logic [31:0] next_pc,
  input wire logic        is_delayed_branch,
  input wire logic        mask_before,
  input wire logic        mask_after,
  input wire logic        instr_match_a,
  input wire logic        instr_match_b,
  input wire logic        opnd_match_a,
  input wire logic        opnd_match_b,
  input wire logic        instr_cfg_a,
  input wire logic        pre_post_select_a,
  input wire logic        chained_mode_bit,
  input wire logic        break_control_wr,
  input wire logic        other_exc,
  input wire logic        other_exc_complete,
  input wire logic [31:0] gpr15,
  input wire logic        exc_take,
  input wire logic        suppress_exec,
  input wire logic [31:0] saved_pc,
  input wire logic [31:0] saved_stack_pointer,
  input wire logic        exception_mask_flag,
  input wire logic        match_flag_a
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // lone channel A event, nothing else competing
  wire q  = ce && retire && !other_exc && !instr_match_b && !opnd_match_b && !chained_mode_bit;
  wire ia = q && instr_match_a && instr_cfg_a && !opnd_match_a;
  ////////////////////////////////////////
  pre_break_a:
    assert property (ia && !pre_post_select_a && !mask_before |=> exc_take && suppress_exec
      && saved_pc == $past(retire_pc)) else $error("pre break take or pc wrong");
  mask_hold_a:
    assert property (ia && !pre_post_select_a && mask_before |=> !exc_take ##1 match_flag_a)
      else $error("masked break misbehaved");
  post_pc_a:
    assert property (ia && pre_post_select_a && !mask_before && !mask_after && !is_delayed_branch
      |=> exc_take && !suppress_exec && saved_pc == $past(next_pc)) else $error("post break pc wrong");
  post_or_a:
    assert property (ia && pre_post_select_a && (mask_before != mask_after) |=> !exc_take)
      else $error("post break ignored mask");
  opnd_pc_a:
    assert property (q && opnd_match_a && !instr_match_a && !instr_cfg_a && !mask_after
      |=> exc_take && saved_pc == $past(next_pc)) else $error("operand break pc wrong");
  mask_set_a:
    assert property (exc_take |-> exception_mask_flag) else $error("mask flag not set on take");
  sp_copy_a:
    assert property (exc_take |-> saved_stack_pointer == $past(gpr15)) else $error("stack copy wrong");
  flag_keep_a:
    assert property ($fell(match_flag_a) |-> $past(break_control_wr) || $past(break_control_wr, 2)
      || $past(break_control_wr, 3)) else $error("flag a dropped without clear");
  compl_flag_a:
    assert property (ce && retire && instr_match_a && instr_cfg_a && pre_post_select_a && other_exc
      && other_exc_complete && !chained_mode_bit |-> ##2 match_flag_a) else $error("flag a not set");
endmodule
bind ubx_ctrl ubx_ctrl_chk chk (.clk, .rst, .ce, .retire, .retire_pc, .next_pc, .is_delayed_branch,
  .mask_before, .mask_after, .instr_match_a, .instr_match_b, .opnd_match_a, .opnd_match_b,
  .instr_cfg_a, .pre_post_select_a, .chained_mode_bit, .break_control_wr, .other_exc,
  .other_exc_complete, .gpr15, .exc_take, .suppress_exec, .saved_pc, .saved_stack_pointer,
  .exception_mask_flag, .match_flag_a);
`default_nettype wire

// ===== test/ubx_ctrl_test.sv
// ubx_ctrl_test: directed scenarios for the break exception control
// assumes ubx_ctrl plus the core stream model, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module ubx_ctrl_test;
  import ubx_pkg::*;
  logic clk, rst, ce, run, retire, is_delayed_branch, branch_taken, is_rte_slot, saved_status_mask;
  logic mask_before, mask_after, instr_match_a, instr_match_b, opnd_match_a, opnd_match_b, data_compare_en;
  logic instr_cfg_a, instr_cfg_b, pre_post_select_a, pre_post_select_b, chained_mode_bit, debug_vector_enable;
  logic break_control_wr, clear_flag_a, clear_flag_b, other_exc, other_exc_async, other_exc_reexec;
  logic other_exc_complete, exc_take, suppress_exec, exception_mask_flag, match_flag_a, match_flag_b;
  logic [31:0] retire_pc, next_pc, branch_target, debug_vector_base, vector_base, other_exc_pc;
  logic [31:0] other_exc_vector, gpr15, saved_pc, exc_vector, saved_stack_pointer, xp, xn, xg;
  logic [11:0] other_exc_code, exception_event_code;
  logic [4:0]  tv [5];
  int          n_fail, n_checks, cyc, n;

  ubx_core_model core (.clk, .rst, .run, .exc_take, .exc_vector, .retire, .retire_pc, .next_pc);
  ubx_ctrl dut (.clk, .rst, .ce, .retire, .retire_pc, .next_pc, .is_delayed_branch, .branch_taken,
    .branch_target, .is_rte_slot, .saved_status_mask, .mask_before, .mask_after, .instr_match_a,
    .instr_match_b, .opnd_match_a, .opnd_match_b, .data_compare_en, .instr_cfg_a, .instr_cfg_b,
    .pre_post_select_a, .pre_post_select_b, .chained_mode_bit, .debug_vector_enable, .debug_vector_base,
    .vector_base, .break_control_wr, .clear_flag_a, .clear_flag_b, .other_exc, .other_exc_async,
    .other_exc_reexec, .other_exc_complete, .other_exc_pc, .other_exc_vector, .other_exc_code, .gpr15,
    .exc_take, .suppress_exec, .saved_pc, .exc_vector, .exception_event_code, .saved_stack_pointer,
    .exception_mask_flag, .match_flag_a, .match_flag_b);
  ////////////////////////////////////////
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle comparator pulse; outputs of that cycle are visible on return
  task automatic hit(input logic ia, input logic ib, input logic oa, input logic ob);
    {instr_match_a, instr_match_b, opnd_match_a, opnd_match_b} = {ia, ib, oa, ob};
    xp = retire_pc;
    xn = next_pc;
    xg = retire_pc ^ 32'h00FF_00FF;
    gpr15 = xg;
    step();
    {instr_match_a, instr_match_b, opnd_match_a, opnd_match_b} = 4'h0;
  endtask
  task automatic wipe();
    {break_control_wr, clear_flag_a, clear_flag_b} = 3'h7;
    step();
    {break_control_wr, clear_flag_a, clear_flag_b} = 3'h0;
    repeat (3) step();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_pre();
    {instr_cfg_a, pre_post_select_a, mask_before, mask_after} = 4'h8;
    hit(1, 0, 0, 0);
    chk("take", 1, exc_take);
    chk("suppress", 1, suppress_exec);
    chk("spc", xp, saved_pc);
    chk("mask flag", 1, exception_mask_flag);
    chk("stack copy", xg, saved_stack_pointer);
    chk("vector", vector_base + BRK_VEC_OFS, exc_vector);
    chk("code", {20'h0, BRK_EVT_CODE}, {20'h0, exception_event_code});
    repeat (3) step();
    chk("flag a held", 1, match_flag_a);
    wipe();
    chk("flag a clear", 0, match_flag_a);
  endtask
  task automatic t_post();
    debug_vector_enable = 1;
    debug_vector_base = 32'h0000_A000;
    pre_post_select_a = 1;
    hit(1, 0, 0, 0);
    chk("post take", 1, exc_take);
    chk("post runs", 0, suppress_exec);
    chk("post spc", xn, saved_pc);
    chk("debug vector", 32'h0000_A000, exc_vector);
    debug_vector_enable = 0;
    wipe();
    // delayed branch: not taken resumes after the slot
    for (int tk = 0; tk < 2; tk++)
    begin
      {is_delayed_branch, branch_taken, branch_target} = {1'b1, tk[0], 32'h0000_3000};
      hit(1, 0, 0, 0);
      chk("branch spc", tk ? 32'h0000_3000 : xp + 32'h4, saved_pc);
      is_delayed_branch = 0;
      wipe();
    end
  endtask
  // columns: instr cfg, post select, mask before, mask after, expect take
  task automatic t_mask();
    tv = '{5'b10100, 5'b11010, 5'b11100, 5'b01101, 5'b01010};
    for (int i = 0; i < 5; i++)
    begin
      {instr_cfg_a, pre_post_select_a, mask_before, mask_after} = tv[i][4:1];
      hit(instr_cfg_a, 0, !instr_cfg_a, 0);
      chk("take by mask", tv[i][0], exc_take);
      if (tv[i][0])
        chk("operand spc", xn, saved_pc);
      step();
      chk("flag by mask", 1, match_flag_a);
      wipe();
    end
    {mask_before, mask_after} = 2'h0;
  endtask
  task automatic t_rte();
    is_rte_slot = 1;
    for (int v = 0; v < 2; v++)
    begin
      {saved_status_mask, mask_after} = {v[0], !v[0]};
      step();
      chk("slot mask", v, exception_mask_flag);
    end
    ce = 0;
    saved_status_mask = 0;
    step();
    chk("frozen mask", 1, exception_mask_flag);
    {ce, is_rte_slot, mask_after} = 3'h4;
    step();
  endtask
  task automatic t_data();
    data_compare_en = 1;
    hit(0, 0, 0, 1);
    n = 0;
    while (exc_take !== 1'b1 && n < 6)
    begin
      step();
      n++;
    end
    chk("data take", 1, exc_take);
    chk("data late", 1, n <= 4);
    hit(0, 0, 0, 1);
    {other_exc, other_exc_async} = 2'h3;
    step();
    {other_exc, other_exc_async} = 2'h0;
    chk("async take", 1, exc_take);
    chk("async code", {20'h0, BRK_EVT_CODE}, {20'h0, exception_event_code});
    chk("first suppressed", 32'h0000_0400, saved_pc);
    data_compare_en = 0;
    wipe();
  endtask
  // B operand two instructions after A; one access never matches both
  task automatic t_chain();
    {chained_mode_bit, instr_cfg_a, pre_post_select_a} = 3'h6;
    hit(1, 0, 0, 0);
    hit(1, 0, 0, 0);
    chk("chain a only", 0, exc_take);
    step();
    hit(0, 0, 0, 1);
    chk("chain take", 1, exc_take);
    step();
    chk("chain flag b", 1, match_flag_b);
    hit(0, 0, 0, 1);
    chk("chain reset", 0, exc_take);
    chained_mode_bit = 0;
    wipe();
  endtask
  task automatic t_both();
    {instr_cfg_a, instr_cfg_b, pre_post_select_a, pre_post_select_b} = 4'hC;
    hit(1, 1, 0, 0);
    chk("both take", 1, exc_take);
    step();
    chk("single take", 0, exc_take);
    chk("both flag a", 1, match_flag_a);
    chk("both flag b", 1, match_flag_b);
    wipe();
  endtask
  task automatic t_contend();
    pre_post_select_a = 1;
    for (int k = 0; k < 2; k++)
    begin
      {other_exc, other_exc_complete, other_exc_reexec} = {1'b1, !k[0], k[0]};
      hit(1, 0, 0, 0);
      other_exc = 0;
      chk("post yields", 32'h0000_0600, exc_vector);
      chk("yield code", 32'h0000_00AA, {20'h0, exception_event_code});
      step();
      if (k == 0)
        chk("yield flag", 1, match_flag_a);
      wipe();
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // hang guard, far above the hundred or so cycles the scenarios need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial
  begin
    {rst, run, n_fail, n_checks, cyc} = {1'b1, 1'b0, 96'h0};
    {ce, is_delayed_branch, branch_taken, is_rte_slot, saved_status_mask, mask_before, mask_after} = 7'h40;
    {instr_match_a, instr_match_b, opnd_match_a, opnd_match_b, data_compare_en, instr_cfg_a} = 6'h0;
    {instr_cfg_b, pre_post_select_a, pre_post_select_b, chained_mode_bit, debug_vector_enable} = 5'h0;
    {break_control_wr, clear_flag_a, clear_flag_b, other_exc, other_exc_async} = 5'h0;
    {other_exc_reexec, other_exc_complete, other_exc_code} = 14'h00AA;
    {branch_target, debug_vector_base, vector_base} = {32'h0, 32'h0, 32'h0000_8000};
    {other_exc_pc, other_exc_vector, gpr15} = {32'h0000_0400, 32'h0000_0600, 32'h0};
    repeat (12) step();
    {rst, run} = 2'b01;
    repeat (2) step();
    t_pre();
    t_post();
    t_mask();
    t_rte();
    t_data();
    t_chain();
    t_both();
    t_contend();
    tally_and_finish();
  end
endmodule
`default_nettype wire
